// >>> design/can_sched_pkg.sv
// constants shared by the transmit scheduler and its slot timers
package can_sched_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
   localparam int TICKS_PER_SEC = 1000 / TICK_MS;
   localparam int ADJ_MAX_S = 129600;
   localparam int SLOTS_DEF = 20;
   localparam int MAX_BYTES = 8;
   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 11;
   localparam logic [10:0] CTRL_OFF = 11'h000;
   localparam logic [10:0] STATUS_OFF = 11'h004;
   localparam logic [10:0] LOAD_OFF = 11'h008;
   localparam logic [10:0] ADJ_OFF = 11'h00C;
   localparam logic [10:0] TIME_OFF = 11'h010;
   localparam logic [10:0] DUE_OFF = 11'h014;
   localparam int SLOT_BASE_BIT = 10;
   localparam int SLOT_IDX_LSB = 5;
   // per-slot word index inside a 32-byte slot window
   localparam logic [2:0] S_CTL = 3'h0;
   localparam logic [2:0] S_ID = 3'h1;
   localparam logic [2:0] S_PER = 3'h2;
   localparam logic [2:0] S_DLY = 3'h3;
   localparam logic [2:0] S_DLO = 3'h4;
   localparam logic [2:0] S_DHI = 3'h5;
   // slot control word fields
   localparam int CTL_PRESENT = 0;
   localparam int CTL_LONG = 1;
   localparam int CTL_ROUTE = 2;
   localparam int CTL_LEN = 4;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [1:0] ROUTE_NONE = 2'h0;
   localparam logic [1:0] ROUTE_LOG = 2'h1;
   localparam logic [1:0] ROUTE_HOST = 2'h2;
   localparam logic [1:0] ROUTE_BOTH = 2'h3;
   typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
endpackage : can_sched_pkg

// >>> design/can_tx_scheduler.sv
// transmit scheduler with twenty slots and a wall clock
`timescale 1ns/1ps
`default_nettype none
module can_tx_scheduler
   import can_sched_pkg::*;
#(
   parameter int SLOTS = SLOTS_DEF,
   parameter int TICK_LEN = TICK_CYCLES,
   parameter bit RTC_FITTED = 1'b1
)
(
   input wire logic clk_sys, // 250 MHz clock
   input wire logic sys_rst, // sync reset, high
   input wire logic [can_sched_pkg::ADDR_W-1:0] reg_addr, // byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, next cycle
   input wire logic tx_ready, // controller takes frame
   output logic tx_valid, // frame offered
   output logic [28:0] frame_identifier, // frame id
   output logic long_identifier_select, // 29-bit id
   output logic [3:0] tx_dlc, // length code
   output logic [63:0] payload_bytes, // byte 0 in low bits
   output logic copy_logger, // copy to logger, pulse
   output logic copy_host, // copy to host, pulse
   output logic [31:0] wall_seconds // clock time
);
   // ----------------------------------------------------------------
   // checks and declarations
   // ----------------------------------------------------------------
   // refuse sizes the slot decode and the prescaler cannot serve
   if (SLOTS < 1 || SLOTS > 32 || TICK_LEN < 2)
   begin : g_bad_param
      $error("slot count or tick length out of range");
   end
   localparam int IDX_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;
   localparam int PRE_W = $clog2(TICK_LEN);
   // slot configuration store
   logic [7:0] ctl_mem [SLOTS];
   logic [31:0] id_mem [SLOTS];
   logic [31:0] per_mem [SLOTS];
   logic [31:0] dly_mem [SLOTS];
   logic [31:0] dlo_mem [SLOTS];
   logic [31:0] dhi_mem [SLOTS];
   logic run;
   logic run_q;
   logic start;
   logic [31:0] load_val;
   logic signed [31:0] adj_val;
   logic [PRE_W-1:0] pre_cnt;
   logic tick;
   logic [6:0] sub_cnt;
   logic [SLOTS-1:0] due;
   logic [SLOTS-1:0] taken;
   logic any_due;
   logic [IDX_W-1:0] pick;
   tx_state_e tx_state;
   logic [15:0] sent_cnt;
   logic slot_hit;
   logic [IDX_W-1:0] w_idx;
   logic [2:0] w_fld;
   logic [3:0] w_len;
   logic [31:0] next_rdata;
   assign slot_hit = reg_addr[SLOT_BASE_BIT];
   assign w_idx = reg_addr[SLOT_IDX_LSB +: IDX_W];
   assign w_fld = reg_addr[4:2];
   assign start = run && !run_q;
   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // byte count above eight is held at eight
   always_comb
   begin
      w_len = reg_wdata[CTL_LEN +: 4];
      if (w_len > 4'(MAX_BYTES))
         w_len = 4'(MAX_BYTES);
   end
   // global control words
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         run <= 1'b0;
         load_val <= WORD_RST;
         adj_val <= WORD_RST;
      end
      else if (reg_wr && !slot_hit)
      begin
         case (reg_addr)
            CTRL_OFF: run <= reg_wdata[0];
            LOAD_OFF: load_val <= reg_wdata;
            ADJ_OFF:
            begin
               if ($signed(reg_wdata) > ADJ_MAX_S)
                  adj_val <= 32'(ADJ_MAX_S);
               else if ($signed(reg_wdata) < -ADJ_MAX_S)
                  adj_val <= -32'(ADJ_MAX_S);
               else
                  adj_val <= reg_wdata;
            end
            default: ;
         endcase
      end
   end
   // per-slot words, out-of-range slot numbers are dropped
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < SLOTS; i++)
         begin
            ctl_mem[i] <= CTL_RST;
            id_mem[i] <= WORD_RST;
            per_mem[i] <= WORD_RST;
            dly_mem[i] <= WORD_RST;
            dlo_mem[i] <= WORD_RST;
            dhi_mem[i] <= WORD_RST;
         end
      end
      else if (reg_wr && slot_hit && 32'(w_idx) < SLOTS)
      begin
         case (w_fld)
            S_CTL: ctl_mem[w_idx] <= {w_len, reg_wdata[3:0]};
            S_ID: id_mem[w_idx] <= reg_wdata;
            S_PER: per_mem[w_idx] <= reg_wdata;
            S_DLY: dly_mem[w_idx] <= reg_wdata;
            S_DLO: dlo_mem[w_idx] <= reg_wdata;
            S_DHI: dhi_mem[w_idx] <= reg_wdata;
            default: ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // read mux, unmapped words read zero
   always_comb
   begin
      next_rdata = WORD_RST;
      if (slot_hit)
      begin
         if (32'(w_idx) < SLOTS)
         begin
            case (w_fld)
               S_CTL: next_rdata = {24'h00_0000, ctl_mem[w_idx]};
               S_ID: next_rdata = id_mem[w_idx];
               S_PER: next_rdata = per_mem[w_idx];
               S_DLY: next_rdata = dly_mem[w_idx];
               S_DLO: next_rdata = dlo_mem[w_idx];
               S_DHI: next_rdata = dhi_mem[w_idx];
               default: next_rdata = WORD_RST;
            endcase
         end
      end
      else
      begin
         case (reg_addr)
            CTRL_OFF: next_rdata = {31'h0000_0000, run};
            STATUS_OFF: next_rdata = {sent_cnt, 15'h0000, tx_valid};
            LOAD_OFF: next_rdata = load_val;
            ADJ_OFF: next_rdata = adj_val;
            TIME_OFF: next_rdata = wall_seconds;
            DUE_OFF: next_rdata = 32'(due);
            default: next_rdata = WORD_RST;
         endcase
      end
   end
   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !reg_rd)
         reg_rdata <= WORD_RST;
      else
         reg_rdata <= next_rdata;
   end
   // ----------------------------------------------------------------
   // shared tick
   // ----------------------------------------------------------------
   // prescaler, one pulse every 10 ms, tick low unless the count wraps
   always_ff @(posedge clk_sys)
   begin
      run_q <= run;
      tick <= 1'b0;
      if (sys_rst || !run)
         pre_cnt <= '0;
      else if (pre_cnt == PRE_W'(TICK_LEN - 1))
      begin
         pre_cnt <= '0;
         tick <= 1'b1;
      end
      else
         pre_cnt <= pre_cnt + PRE_W'(1);
   end
   // ----------------------------------------------------------------
   // slots
   // ----------------------------------------------------------------
   // one timer per slot, all on the same tick
   for (genvar g = 0; g < SLOTS; g++)
   begin : g_slot
      slot_timer u_slot (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .enable(run && ctl_mem[g][CTL_PRESENT]),
         .tick(tick),
         .period_ms(per_mem[g]),
         .delay_ms(dly_mem[g]),
         .taken(taken[g]),
         .due(due[g])
      );
   end
   // lowest waiting slot goes first
   always_comb
   begin
      pick = '0;
      any_due = 1'b0;
      for (int i = SLOTS - 1; i >= 0; i--)
      begin
         if (due[i])
         begin
            pick = IDX_W'(i);
            any_due = 1'b1;
         end
      end
      taken = '0;
      if (tx_state == TX_IDLE && any_due)
         taken[pick] = 1'b1;
   end
   // ----------------------------------------------------------------
   // frame launch
   // ----------------------------------------------------------------
   // offer a frame and hold it until the controller takes it
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tx_state <= TX_IDLE;
         tx_valid <= 1'b0;
         frame_identifier <= '0;
         long_identifier_select <= 1'b0;
         tx_dlc <= '0;
         payload_bytes <= '0;
         sent_cnt <= '0;
      end
      else
      begin
         case (tx_state)
            TX_IDLE:
            begin
               if (any_due)
               begin
                  tx_state <= TX_SEND;
                  tx_valid <= 1'b1;
                  long_identifier_select <= ctl_mem[pick][CTL_LONG];
                  if (ctl_mem[pick][CTL_LONG])
                     frame_identifier <= id_mem[pick][28:0];
                  else
                     frame_identifier <= {18'h0_0000, id_mem[pick][10:0]};
                  tx_dlc <= ctl_mem[pick][CTL_LEN +: 4];
                  payload_bytes <= {dhi_mem[pick], dlo_mem[pick]};
               end
            end
            TX_SEND:
            begin
               if (tx_ready)
               begin
                  tx_state <= TX_IDLE;
                  tx_valid <= 1'b0;
                  sent_cnt <= sent_cnt + 16'h0001;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end
   // local copy pulses from the route code, low unless a frame launches
   always_ff @(posedge clk_sys)
   begin
      copy_logger <= 1'b0;
      copy_host <= 1'b0;
      if (!sys_rst && tx_state == TX_IDLE && any_due)
      begin
         copy_logger <= ctl_mem[pick][CTL_ROUTE +: 2] inside {ROUTE_LOG, ROUTE_BOTH};
         copy_host <= ctl_mem[pick][CTL_ROUTE +: 2] inside {ROUTE_HOST, ROUTE_BOTH};
      end
   end
   // ----------------------------------------------------------------
   // wall clock
   // ----------------------------------------------------------------
   // seconds from ticks, load and adjust at start, kept when fitted
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         sub_cnt <= '0;
         if (!RTC_FITTED)
            wall_seconds <= WORD_RST;
      end
      else if (start)
      begin
         sub_cnt <= '0;
         if (load_val != WORD_RST)
            wall_seconds <= load_val + adj_val;
         else
            wall_seconds <= wall_seconds + adj_val;
      end
      else if (tick)
      begin
         if (sub_cnt == 7'(TICKS_PER_SEC - 1))
         begin
            sub_cnt <= '0;
            wall_seconds <= wall_seconds + 32'h0000_0001;
         end
         else
            sub_cnt <= sub_cnt + 7'h01;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_launch;
      tx_state == TX_IDLE && any_due;
   endsequence
   sequence s_hold;
      tx_valid && !tx_ready;
   endsequence
   chk_launch_offer: assert property (s_launch |=> tx_valid)
      else $error("due slot not offered");
   chk_frame_hold: assert property (s_hold |=> tx_valid && $stable(payload_bytes))
      else $error("frame dropped before taken");
   chk_dlc_limit: assert property (tx_valid |-> tx_dlc <= 4'(MAX_BYTES))
      else $error("length code above eight");
   chk_std_id: assert property (tx_valid && !long_identifier_select |-> frame_identifier[28:11] == '0)
      else $error("standard id wider than 11 bits");
   chk_route_none: assert property (
      (s_launch and ctl_mem[pick][CTL_ROUTE +: 2] == ROUTE_NONE) |=> !copy_logger && !copy_host)
      else $error("copy made for route none");
   chk_pick_lowest: assert property (s_launch |-> (due & ((32'h0000_0001 << pick) - 32'h0000_0001)) == '0)
      else $error("higher slot sent first");
   chk_load_time: assert property (start && load_val != WORD_RST |=> wall_seconds == $past(load_val) + $past(adj_val))
      else $error("time not loaded");
   chk_adj_range: assert property (adj_val <= ADJ_MAX_S && adj_val >= -ADJ_MAX_S)
      else $error("adjustment out of range");
   chk_tick_space: assert property (tick |=> !tick [*1])
      else $error("tick longer than one cycle");
   chk_read_once: assert property (!reg_rd |=> reg_rdata == WORD_RST)
      else $error("read data outside read cycle");
endmodule : can_tx_scheduler
`default_nettype wire

// >>> design/slot_timer.sv
// one transmit slot: delay and period counting on the shared tick
`timescale 1ns/1ps
`default_nettype none
module slot_timer
   import can_sched_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // sync reset, high
   input wire logic enable, // slot present and running
   input wire logic tick, // 10 ms pulse
   input wire logic [31:0] period_ms, // period in ms
   input wire logic [31:0] delay_ms, // delay in ms
   input wire logic taken, // frame launched
   output logic due // frame waiting
);
   logic en_q;
   logic armed;
   logic [31:0] cnt;
   logic [31:0] per_t;
   logic [31:0] dly_t;
   logic fire;

   // ms settings to tick counts, a short period still takes one tick
   always_comb
   begin
      per_t = period_ms / 32'(TICK_MS);
      if (period_ms != WORD_RST && per_t == WORD_RST)
         per_t = 32'h0000_0001;
      dly_t = delay_ms / 32'(TICK_MS);
   end

   assign fire = armed && tick && (cnt == WORD_RST);

   // arm on enable, fire after delay, reload with the period
   always_ff @(posedge clk_sys)
   begin
      en_q <= enable;
      if (sys_rst || !enable)
      begin
         armed <= 1'b0;
         cnt <= WORD_RST;
      end
      else if (!en_q)
      begin
         armed <= 1'b1;
         cnt <= dly_t;
      end
      else if (armed && tick)
      begin
         if (cnt != WORD_RST)
            cnt <= cnt - 32'h0000_0001;
         else if (per_t == WORD_RST)
            armed <= 1'b0;
         else
            cnt <= per_t - 32'h0000_0001;
      end
   end

   // waiting flag, a new fire wins over the take
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !enable)
         due <= 1'b0;
      else if (fire)
         due <= 1'b1;
      else if (taken)
         due <= 1'b0;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   chk_single_disarm: assert property (
      fire && per_t == WORD_RST && enable |=> !armed)
      else $error("single shot slot stayed armed");
   chk_fire_due: assert property (
      fire && enable |=> due)
      else $error("fire did not raise due");
endmodule : slot_timer
`default_nettype wire

// >>> testbench/can_ctrl_model.sv
// behavioural can controller that takes offered frames after a varying stall
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model
(
   input wire logic clk_sys, // system clock
   input wire logic sys_rst, // sync reset, high
   input wire logic tx_valid, // frame offered
   output logic tx_ready // frame accepted
);
   logic [1:0] stall;
   logic [1:0] wait_cnt;
   // ----------------------------------------------------------------
   // acceptance handshake
   // ----------------------------------------------------------------
   // stall walks 0..3 so prompt and slow answers are both seen
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tx_ready <= 1'b0;
         stall <= 2'h0;
         wait_cnt <= 2'h0;
      end
      else if (tx_ready)
      begin
         tx_ready <= 1'b0;
         stall <= stall + 2'h1;
         wait_cnt <= 2'h0;
      end
      else if (tx_valid && wait_cnt == stall)
         tx_ready <= 1'b1;
      else if (tx_valid)
         wait_cnt <= wait_cnt + 2'h1;
   end
endmodule : can_ctrl_model
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the transmit scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import can_sched_pkg::*;
   localparam int TLEN = 40;
   localparam int N_EXP = 11;
   typedef struct {logic [28:0] id; logic lng; logic [3:0] dlc; logic [63:0] pl;
      logic cl; logic ch;} frame_s;
   logic clk_sys;
   logic sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic tx_ready;
   logic tx_valid;
   logic [28:0] frame_identifier;
   logic long_identifier_select;
   logic [3:0] tx_dlc;
   logic [63:0] payload_bytes;
   logic copy_logger;
   logic copy_host;
   logic [31:0] wall_seconds;
   logic cl = 1'b0;
   logic ch = 1'b0;
   logic was_valid = 1'b0;
   logic [31:0] d;
   logic [31:0] t0;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int n_log = 0;
   int n_host = 0;
   frame_s recs [$];
   // slot words: ctl, id, period, delay, data low, data high
   logic [31:0] cfg [4][6] = '{
      '{32'h0000_002D, 32'h0000_0123, 32'h0000_0000, 32'h0000_0014, 32'h0000_BBAA, 32'h0},
      '{32'h0000_0087, 32'hFABC_DEF0, 32'h0000_001E, 32'h0, 32'h4433_2211, 32'h8877_6655},
      '{32'h0000_0009, 32'h0000_77FF, 32'h0000_001E, 32'h0000_000A, 32'hDEAD_BEEF, 32'h1},
      '{32'h0000_00C1, 32'h0000_0005, 32'h0000_001E, 32'h0, 32'h0403_0201, 32'h0807_0605}};
   logic [28:0] eid [4] = '{29'h123, 29'h1ABC_DEF0, 29'h7FF, 29'h5};
   logic elong [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
   logic [3:0] edlc [4] = '{4'h2, 4'h8, 4'h0, 4'h8};
   logic [1:0] eroute [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
   int exp_seq [N_EXP] = '{1, 3, 2, 0, 1, 3, 2, 1, 3, 2, 2};

   can_tx_scheduler #(.SLOTS(SLOTS_DEF), .TICK_LEN(TLEN), .RTC_FITTED(1'b1))
   can_tx_scheduler_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .frame_identifier(frame_identifier),
      .long_identifier_select(long_identifier_select), .tx_dlc(tx_dlc),
      .payload_bytes(payload_bytes), .copy_logger(copy_logger), .copy_host(copy_host),
      .wall_seconds(wall_seconds));
   can_ctrl_model can_ctrl_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .tx_valid(tx_valid), .tx_ready(tx_ready));

   // ----------------------------------------------------------------
   // clock, monitor, timeout
   // ----------------------------------------------------------------
   // 250 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // record taken frames with the copy flags of their first offered cycle
   always @(posedge clk_sys)
   begin
      cycles++;
      if (copy_logger === 1'b1) n_log++;
      if (copy_host === 1'b1) n_host++;
      if (tx_valid === 1'b1 && was_valid !== 1'b1)
      begin
         cl = copy_logger;
         ch = copy_host;
      end
      was_valid = tx_valid;
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         recs.push_back('{frame_identifier, long_identifier_select, tx_dlc, payload_bytes,
            cl, ch});
      if (cycles == 10000)
      begin
         fail_count++;
         $display("ERROR t=%0t run did not finish", $time);
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic wr(input logic [10:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task automatic rdchk(input logic [10:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      check(64'(d), 64'(exp), what);
   endtask : rdchk
   function automatic logic [10:0] sa(input int s, input int w);
      return 11'h400 + 11'(s * 32) + 11'(w * 4);
   endfunction : sa
   task automatic check_frame(input int i, input int s);
      logic [63:0] mask;
      mask = '0;
      for (int b = 0; b < 8; b++)
         if (b < edlc[s]) mask[8*b +: 8] = 8'hFF;
      check(64'(recs[i].id), 64'(eid[s]), "identifier");
      check(64'(recs[i].lng), 64'(elong[s]), "long select");
      check(64'(recs[i].dlc), 64'(edlc[s]), "length code");
      check(recs[i].pl & mask, {cfg[s][5], cfg[s][4]} & mask, "payload");
      check(64'({recs[i].ch, recs[i].cl}), 64'(eroute[s]), "copy route");
   endtask : check_frame
   task automatic restart(input logic [31:0] ld, input logic [31:0] adj);
      wr(LOAD_OFF, ld);
      wr(ADJ_OFF, adj);
      wr(CTRL_OFF, 32'h0);
      wr(CTRL_OFF, 32'h1);
      repeat (3) @(posedge clk_sys);
   endtask : restart

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // reset values and refused accesses
      rdchk(CTRL_OFF, WORD_RST, "ctrl reset");
      rdchk(ADJ_OFF, WORD_RST, "adjust reset");
      for (int w = 0; w < 6; w++)
         rdchk(sa(0, w), WORD_RST, "slot reset");
      wr(11'h018, 32'hFFFF_FFFF);
      rdchk(11'h018, WORD_RST, "unmapped");
      wr(sa(SLOTS_DEF, 1), 32'hFFFF_FFFF);
      rdchk(sa(SLOTS_DEF, 1), WORD_RST, "slot past last");
      wr(DUE_OFF, 32'hFFFF_FFFF);
      rdchk(DUE_OFF, WORD_RST, "due read only");
      $display("test reset_map done");
      // four slots: one-shot, periodic with phase offsets, ties on one tick
      for (int s = 0; s < 4; s++)
         for (int w = 0; w < 6; w++)
            wr(sa(s, w), cfg[s][w]);
      rdchk(sa(3, 0), 32'h0000_0081, "length clamp");
      rdchk(sa(1, 2), 32'h0000_001E, "period readback");
      wr(LOAD_OFF, 32'h0000_03E8);
      wr(ADJ_OFF, 32'hFFFF_FFFB);
      wr(CTRL_OFF, 32'h0000_0001);
      repeat (305) @(posedge clk_sys);
      wr(sa(1, 0), 32'h0000_0086);
      wr(sa(3, 0), 32'h0000_00C0);
      repeat (150) @(posedge clk_sys);
      check(64'(recs.size()), 64'(N_EXP), "frame count");
      for (int i = 0; i < N_EXP && i < recs.size(); i++)
         check_frame(i, exp_seq[i]);
      check(64'(n_log), 64'h4, "logger copies");
      check(64'(n_host), 64'h5, "host copies");
      rdchk(STATUS_OFF, {16'(N_EXP), 16'h0}, "sent count");
      $display("test schedule done");
      // clock load, adjust, clamp and seconds count
      t0 = 32'h0000_03E8 - 32'h0000_0005;
      rdchk(TIME_OFF, t0, "time loaded");
      check(64'(wall_seconds), 64'(t0), "wall seconds");
      repeat (3700) @(posedge clk_sys);
      t0 = t0 + 32'h1;
      rdchk(TIME_OFF, t0, "seconds count");
      restart(32'h0, 32'h0003_0D40);
      rdchk(TIME_OFF, t0 + 32'(ADJ_MAX_S), "positive clamp");
      restart(32'h0, 32'hFFFC_F2C0);
      rdchk(TIME_OFF, t0, "negative clamp kept time");
      restart(32'h0000_0007, 32'h0);
      rdchk(TIME_OFF, 32'h0000_0007, "time reloaded");
      check(64'(wall_seconds), 64'h7, "wall after reload");
      wr(LOAD_OFF, 32'h0);
      // mid-run reset: the fitted clock keeps its count, scheduling stops
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdchk(TIME_OFF, 32'h0000_0007, "time kept over reset");
      rdchk(CTRL_OFF, WORD_RST, "run cleared by reset");
      $display("test wall_clock done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
